// ---- design/dmacc_arb.sv ----
// Programmable priority arbiter over the requesting channels.
`timescale 1ns/1ps
`default_nettype none
module dmacc_arb #(
	parameter int N = 8
) (
	input wire logic [N-1:0] i_req,
	input wire logic [N-1:0][1:0] i_pri,
	output logic o_valid,
	output logic [2:0] o_idx
);
	logic [1:0] best_pri;

	// The three-bit index serves at most eight channels.
	if (N < 1 || N > 8) begin : g_bad_n
		$error("N must lie between 1 and 8");
	end

	// A later channel wins only with strictly higher priority.
	always_comb begin
		o_valid = 1'b0;
		o_idx = 3'h0;
		best_pri = 2'h0;
		for (int c = 0; c < N; c++) begin
			if (i_req[c] && (!o_valid || i_pri[c] > best_pri)) begin
				o_valid = 1'b1;
				o_idx = 3'(c);
				best_pri = i_pri[c];
			end
		end
	end
endmodule
`default_nettype wire

// ---- design/dmacc_pkg.sv ----
// Constants, offsets and field positions shared by the channel controller.
// Functional notes
// - Each channel's register set sits at its own base; channel two 0xA0000030.
// - Per channel: config 0x00, count 0x04, periph 0x08, mem 0x0C; reset zero.
// - Config bit 0 enables the channel.
// - Config bits 1..3 gate done, half and error interrupts.
// - Config bit 4 picks direction: 0 periph to memory, 1 memory to periph.
// - Config bit 5 selects auto-reload; count reloads and channel keeps running.
// - Bits 6 and 7 step the periph and memory addresses per element.
// - Fields 9:8 and 11:10 give element width: 8, 16 or 32 bits.
// - Field 13:12 gives arbitration priority, low to very high.
// - Bit 14 selects memory copy, running without a periph request.
// - Count is 16 bits in 15:0; upper bits read zero.
// - Count is writable only while disabled; enabled it shows remaining.
// - Count drops by one after each finished element.
// - At completion count stays zero, or reloads in auto-reload mode.
// - A channel with zero count serves nothing.
// - Periph accesses are aligned to the periph element width.
// - Memory accesses are aligned to the memory element width.
// - Writing 1 to a channel's clear-all bit clears its four flags.
package dmacc_pkg;
	localparam int MAX_CH = 8;
	localparam int CH_IDX_W = 3;
	localparam logic [31:0] BUS_BASE = 32'hA0000000;
	localparam logic [31:0] STAT_OFS = 32'h00000000;
	localparam logic [31:0] CLR_OFS = 32'h00000004;
	localparam logic [31:0] CH0_OFS = 32'h00000008;
	localparam logic [31:0] CH_STRIDE = 32'h00000014;
	localparam logic [1:0] REG_CFG = 2'h0;
	localparam logic [1:0] REG_CNT = 2'h1;
	localparam logic [1:0] REG_PA = 2'h2;
	localparam logic [1:0] REG_MA = 2'h3;
	localparam logic [31:0] RESET_VAL = 32'h00000000;
	localparam int CFG_W = 15;
	localparam int CNT_W = 16;
	localparam int EN_BIT = 0;
	localparam int DIR_BIT = 4;
	localparam int AUTO_RELOAD_MODE_BIT = 5;
	localparam int PSTEP_BIT = 6;
	localparam int MSTEP_BIT = 7;
	localparam int PW_LO = 8;
	localparam int MW_LO = 10;
	localparam int PRI_LO = 12;
	localparam int COPY_BIT = 14;
	localparam int ANY_FLG = 0;
	localparam int DONE_FLG = 1;
	localparam int HALF_FLG = 2;
	localparam int ERR_FLG = 3;
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_RD = 2'b01,
		ENG_WR = 2'b10
	} dmacc_eng_t;
endpackage

// ---- design/dmacc_sync.sv ----
// Two-stage synchroniser for request pins.
`timescale 1ns/1ps
`default_nettype none
module dmacc_sync #(
	parameter int W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dmacc_sync_t;
	dmacc_sync_t s_reg, s_next;

	// The first stage feeds only the second.
	always_comb begin
		s_next.s1 = i_d;
		s_next.s2 = s_reg.s1;
	end

	// Both stages clear on reset.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_q = s_reg.s2;
endmodule
`default_nettype wire

// ---- design/dmacc_top.sv ----
// Multi-channel transfer engine with its register file and bus master.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module dmacc_top
	import dmacc_pkg::*;
#(
	parameter int NUM_CH = 8
) (
	input wire logic I_CLOCK,
	input wire logic I_RST,
	input wire logic [31:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic [NUM_CH-1:0] I_PERIPH_REQ,
	output logic [31:0] O_M_ADDRESS,
	output logic O_M_READ,
	output logic O_M_WRITE,
	output logic [31:0] O_M_WRITEDATA,
	output logic [1:0] O_M_SIZE,
	input wire logic [31:0] I_M_READDATA,
	input wire logic I_M_WAITREQUEST,
	input wire logic I_M_ERROR,
	output logic [NUM_CH-1:0] O_CH_IRQ
);
	typedef struct packed {
		logic [NUM_CH-1:0][CFG_W-1:0] cfg;
		logic [NUM_CH-1:0][CNT_W-1:0] cnt;
		logic [NUM_CH-1:0][CNT_W-1:0] rld;
		logic [NUM_CH-1:0][31:0] pa;
		logic [NUM_CH-1:0][31:0] ma;
		logic [NUM_CH-1:0][31:0] pp;
		logic [NUM_CH-1:0][31:0] mp;
		logic [NUM_CH-1:0][3:0] flg;
		dmacc_eng_t eng;
		logic [CH_IDX_W-1:0] act;
		logic [31:0] data;
		logic [31:0] m_addr;
		logic m_rd;
		logic m_wr;
		logic [31:0] m_wdata;
		logic [1:0] m_size;
		logic avs_wait;
		logic [31:0] avs_rdata;
		logic [NUM_CH-1:0] irq;
	} dmacc_state_t;

	dmacc_state_t s_reg, s_next;
	logic [NUM_CH-1:0] req_sync;
	logic [NUM_CH-1:0] ch_req;
	logic [NUM_CH-1:0][1:0] ch_pri;
	logic arb_valid;
	logic [2:0] arb_idx;
	logic avs_req, wr_ok, ch_hit, stat_hit, clr_hit;
	logic [CH_IDX_W-1:0] hch;
	logic [1:0] hreg;
	logic [31:0] rd_val, tmp;
	logic [NUM_CH-1:0][3:0] clr, set;
	logic [1:0] pw, mw;
	logic [CNT_W-1:0] cnt_dec;
	logic [NUM_CH-1:0] irq_cause;

	// Channel count must fit the shared four-bit-per-channel flag words.
	if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
		$error("NUM_CH must lie between 1 and 8");
	end

	// Width code 01 is a halfword, 10 and the spare 11 are words.
	function automatic logic [31:0] align(input logic [31:0] a,
			input logic [1:0] w);
		if (w == 2'h0) begin
			return a;
		end else if (w == 2'h1) begin
			return {a[31:1], 1'b0};
		end
		return {a[31:2], 2'h0};
	endfunction

	function automatic logic [31:0] wbytes(input logic [1:0] w);
		if (w == 2'h0) begin
			return 32'h00000001;
		end else if (w == 2'h1) begin
			return 32'h00000002;
		end
		return 32'h00000004;
	endfunction

	// Byte lanes of a write merged onto the old word.
	function automatic logic [31:0] merge(input logic [31:0] o,
			input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	dmacc_sync #(.W(NUM_CH)) u_sync (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_d(I_PERIPH_REQ),
		.o_q(req_sync)
	);

	// A channel asks for service only when enabled with work left.
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ch_req[c] = s_reg.cfg[c][EN_BIT] && s_reg.cnt[c] != '0
				&& (s_reg.cfg[c][COPY_BIT] || req_sync[c]);
			ch_pri[c] = s_reg.cfg[c][PRI_LO +: 2];
		end
	end

	dmacc_arb #(.N(NUM_CH)) u_arb (
		.i_req(ch_req),
		.i_pri(ch_pri),
		.o_valid(arb_valid),
		.o_idx(arb_idx)
	);

	// Address decode of the status, clear and channel registers.
	always_comb begin
		avs_req = I_AVS_READ || I_AVS_WRITE;
		wr_ok = I_AVS_WRITE && !s_reg.avs_wait;
		stat_hit = I_AVS_ADDRESS == BUS_BASE + STAT_OFS;
		clr_hit = I_AVS_ADDRESS == BUS_BASE + CLR_OFS;
		ch_hit = 1'b0;
		hch = '0;
		hreg = REG_CFG;
		for (int c = 0; c < NUM_CH; c++) begin
			for (int r = 0; r < 4; r++) begin
				if (I_AVS_ADDRESS == BUS_BASE + CH0_OFS
						+ 32'(c) * CH_STRIDE + 32'(r) * 32'h4) begin
					ch_hit = 1'b1;
					hch = CH_IDX_W'(c);
					hreg = 2'(r);
				end
			end
		end
		rd_val = RESET_VAL;
		if (stat_hit) begin
			rd_val = 32'(s_reg.flg);
		end else if (ch_hit && hreg == REG_CFG) begin
			rd_val = 32'(s_reg.cfg[hch]);
		end else if (ch_hit && hreg == REG_CNT) begin
			rd_val = 32'(s_reg.cnt[hch]);
		end else if (ch_hit && hreg == REG_PA) begin
			rd_val = s_reg.pa[hch];
		end else if (ch_hit && hreg == REG_MA) begin
			rd_val = s_reg.ma[hch];
		end
	end

	// Register writes, flag updates and the element engine.
	always_comb begin
		s_next = s_reg;
		clr = '0;
		set = '0;
		tmp = RESET_VAL;
		pw = s_reg.cfg[s_reg.act][PW_LO +: 2];
		mw = s_reg.cfg[s_reg.act][MW_LO +: 2];
		cnt_dec = s_reg.cnt[s_reg.act] - CNT_W'(1);
		s_next.avs_wait = !(avs_req && s_reg.avs_wait);
		if (avs_req && s_reg.avs_wait) begin
			s_next.avs_rdata = rd_val;
		end
		if (wr_ok && clr_hit) begin
			tmp = merge(RESET_VAL, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
			for (int c = 0; c < NUM_CH; c++) begin
				clr[c] = tmp[4*c +: 4];
				if (tmp[4*c + ANY_FLG]) begin
					clr[c] = 4'hF;
				end
			end
		end else if (wr_ok && ch_hit && hreg == REG_CFG) begin
			tmp = merge(32'(s_reg.cfg[hch]), I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
			s_next.cfg[hch] = tmp[CFG_W-1:0];
			if (tmp[EN_BIT] && !s_reg.cfg[hch][EN_BIT]) begin
				s_next.pp[hch] = s_reg.pa[hch];
				s_next.mp[hch] = s_reg.ma[hch];
			end
		end else if (wr_ok && ch_hit && hreg == REG_CNT) begin
			tmp = merge(32'(s_reg.cnt[hch]), I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
			if (!s_reg.cfg[hch][EN_BIT]) begin
				s_next.cnt[hch] = tmp[CNT_W-1:0];
				s_next.rld[hch] = tmp[CNT_W-1:0];
			end
		end else if (wr_ok && ch_hit && hreg == REG_PA) begin
			s_next.pa[hch] = merge(s_reg.pa[hch], I_AVS_WRITEDATA,
				I_AVS_BYTEENABLE);
		end else if (wr_ok && ch_hit && hreg == REG_MA) begin
			s_next.ma[hch] = merge(s_reg.ma[hch], I_AVS_WRITEDATA,
				I_AVS_BYTEENABLE);
		end
		// The engine finishes an element even if software disables mid-way.
		case (s_reg.eng)
			ENG_IDLE: begin
				if (arb_valid) begin
					s_next.act = arb_idx;
					s_next.m_rd = 1'b1;
					s_next.eng = ENG_RD;
					if (s_reg.cfg[arb_idx][DIR_BIT]) begin
						s_next.m_size = s_reg.cfg[arb_idx][MW_LO +: 2];
						s_next.m_addr = align(s_reg.mp[arb_idx],
							s_reg.cfg[arb_idx][MW_LO +: 2]);
					end else begin
						s_next.m_size = s_reg.cfg[arb_idx][PW_LO +: 2];
						s_next.m_addr = align(s_reg.pp[arb_idx],
							s_reg.cfg[arb_idx][PW_LO +: 2]);
					end
				end
			end
			ENG_RD: begin
				if (!I_M_WAITREQUEST) begin
					s_next.m_rd = 1'b0;
					if (I_M_ERROR) begin
						s_next.eng = ENG_IDLE;
						set[s_reg.act][ERR_FLG] = 1'b1;
						s_next.cfg[s_reg.act][EN_BIT] = 1'b0;
					end else begin
						s_next.eng = ENG_WR;
						s_next.m_wr = 1'b1;
						s_next.m_wdata = I_M_READDATA;
						if (s_reg.cfg[s_reg.act][DIR_BIT]) begin
							s_next.m_size = pw;
							s_next.m_addr = align(s_reg.pp[s_reg.act], pw);
						end else begin
							s_next.m_size = mw;
							s_next.m_addr = align(s_reg.mp[s_reg.act], mw);
						end
					end
				end
			end
			ENG_WR: begin
				if (!I_M_WAITREQUEST) begin
					s_next.m_wr = 1'b0;
					s_next.eng = ENG_IDLE;
					if (I_M_ERROR) begin
						set[s_reg.act][ERR_FLG] = 1'b1;
						s_next.cfg[s_reg.act][EN_BIT] = 1'b0;
					end else begin
						s_next.cnt[s_reg.act] = cnt_dec;
						if (s_reg.cfg[s_reg.act][PSTEP_BIT]) begin
							s_next.pp[s_reg.act] = s_reg.pp[s_reg.act] + wbytes(pw);
						end
						if (s_reg.cfg[s_reg.act][MSTEP_BIT]) begin
							s_next.mp[s_reg.act] = s_reg.mp[s_reg.act] + wbytes(mw);
						end
						if (cnt_dec == (s_reg.rld[s_reg.act] >> 1)) begin
							set[s_reg.act][HALF_FLG] = 1'b1;
						end
						if (cnt_dec == '0) begin
							set[s_reg.act][DONE_FLG] = 1'b1;
							if (s_reg.cfg[s_reg.act][AUTO_RELOAD_MODE_BIT]) begin
								s_next.cnt[s_reg.act] = s_reg.rld[s_reg.act];
								s_next.pp[s_reg.act] = s_reg.pa[s_reg.act];
								s_next.mp[s_reg.act] = s_reg.ma[s_reg.act];
							end
						end
					end
				end
			end
			default: begin
				s_next.eng = ENG_IDLE;
			end
		endcase
		// A set in the same cycle as a clear wins; interrupts follow enables.
		for (int c = 0; c < NUM_CH; c++) begin
			set[c][ANY_FLG] = |set[c][3:1];
			s_next.flg[c] = (s_reg.flg[c] & ~clr[c]) | set[c];
			s_next.irq[c] = |(s_next.flg[c][3:1] & s_next.cfg[c][3:1]);
		end
	end

	// All state resets to zero except the idle-high waitrequest.
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			s_reg <= '0;
			s_reg.avs_wait <= 1'b1;
			s_reg.eng <= ENG_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign O_AVS_READDATA = s_reg.avs_rdata;
	assign O_AVS_WAITREQUEST = s_reg.avs_wait;
	assign O_M_ADDRESS = s_reg.m_addr;
	assign O_M_READ = s_reg.m_rd;
	assign O_M_WRITE = s_reg.m_wr;
	assign O_M_WRITEDATA = s_reg.m_wdata;
	assign O_M_SIZE = s_reg.m_size;
	assign O_CH_IRQ = s_reg.irq;

	// Expected interrupt levels rebuilt from the registered flags and enables.
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			irq_cause[c] = |(s_reg.flg[c][3:1] & s_reg.cfg[c][3:1]);
		end
	end

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	sequence avs_first;
		avs_req && s_reg.avs_wait;
	endsequence
	sequence avs_done;
		avs_req && !O_AVS_WAITREQUEST;
	endsequence
	sequence elem_ok;
		s_reg.eng == ENG_WR && !I_M_WAITREQUEST && !I_M_ERROR;
	endsequence

	bus_ack_a: assert property (
		avs_first |=> !O_AVS_WAITREQUEST)
		else $error("register access not acknowledged after one cycle");
	base_read_a: assert property (
		avs_first and I_AVS_READ && !stat_hit && !ch_hit
		|=> avs_done ##0 O_AVS_READDATA == 32'h0)
		else $error("unmapped read did not return zero");
	count_lock_a: assert property (
		I_AVS_WRITE && !s_reg.avs_wait && ch_hit && hreg == REG_CNT
		&& s_reg.cfg[hch][EN_BIT] && s_reg.eng == ENG_IDLE && !arb_valid
		|=> s_reg.cnt[$past(hch)] == $past(s_reg.cnt[hch]))
		else $error("count changed by a write while enabled");
	zero_idle_a: assert property (
		s_reg.eng == ENG_IDLE && arb_valid |-> s_reg.cnt[arb_idx] != '0
		##1 O_M_READ)
		else $error("channel with zero count was served");
	count_step_a: assert property (
		elem_ok and s_reg.cnt[s_reg.act] > 16'h0001
		|=> s_reg.cnt[$past(s_reg.act)] == $past(cnt_dec))
		else $error("count did not drop by one");
	word_align_a: assert property (
		(O_M_READ || O_M_WRITE) && O_M_SIZE[1] |-> O_M_ADDRESS[1:0] == 2'h0)
		else $error("word access not aligned");
	half_align_a: assert property (
		(O_M_READ || O_M_WRITE) && O_M_SIZE == 2'h1 |-> !O_M_ADDRESS[0])
		else $error("halfword access not aligned");
	err_stop_a: assert property (
		s_reg.eng != ENG_IDLE && !I_M_WAITREQUEST && I_M_ERROR
		|=> !s_reg.cfg[$past(s_reg.act)][EN_BIT]
		&& s_reg.flg[$past(s_reg.act)][ERR_FLG] && s_reg.eng == ENG_IDLE)
		else $error("bus error did not stop the channel");
	irq_gate_a: assert property (
		O_CH_IRQ == irq_cause)
		else $error("interrupt level does not match enabled flags");
	reload_a: assert property (
		elem_ok and cnt_dec == '0 |=> s_reg.cnt[$past(s_reg.act)] ==
		($past(s_reg.cfg[s_reg.act][AUTO_RELOAD_MODE_BIT]) ?
		$past(s_reg.rld[s_reg.act]) : 16'h0000))
		else $error("count wrong at completion");
endmodule
`default_nettype wire

// ---- sim/dma_channel_config_test.sv ----
// Self-checking bench for the channel controller and its master bus.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_config_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [31:0] a_addr = 32'h0;
	logic a_rd = 1'b0;
	logic a_wr = 1'b0;
	logic [31:0] a_wd = 32'h0;
	logic [31:0] rdata, m_addr, m_wd, s_rd;
	logic waitr, m_rd, m_wr, s_wait, s_err;
	logic [1:0] m_size;
	logic [7:0] preq = 8'h0;
	logic [7:0] irq;
	logic [31:0] fault = 32'hFFFFFFFF;
	logic [31:0] xs = 32'h46;
	logic [1:0] wsz = 2'h0;
	logic [63:0] exp_q [$];
	int bad_count = 0;
	int checks = 0;
	localparam logic [31:0] FLAGS_A = 32'hA0000000;
	localparam logic [31:0] CL = 32'hA0000004;
	localparam logic [31:0] PT = 32'h5A5A0000;

	dmacc_top #(.NUM_CH(8)) uut (.I_CLOCK(clk), .I_RST(rst),
		.I_AVS_ADDRESS(a_addr), .I_AVS_READ(a_rd), .I_AVS_WRITE(a_wr),
		.I_AVS_WRITEDATA(a_wd), .I_AVS_BYTEENABLE(4'hF),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitr),
		.I_PERIPH_REQ(preq), .O_M_ADDRESS(m_addr), .O_M_READ(m_rd),
		.O_M_WRITE(m_wr), .O_M_WRITEDATA(m_wd), .O_M_SIZE(m_size),
		.I_M_READDATA(s_rd), .I_M_WAITREQUEST(s_wait), .I_M_ERROR(s_err),
		.O_CH_IRQ(irq));
	dmacc_slave p (.i_clk(clk), .i_rst(rst), .i_addr(m_addr),
		.i_read(m_rd), .i_write(m_wr), .i_wdata(m_wd), .i_fault(fault),
		.o_rdata(s_rd), .o_wait(s_wait), .o_err(s_err));

	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		xs ^= xs << 13;
		xs ^= xs >> 17;
		xs ^= xs << 5;
		return xs;
	endfunction

	function automatic logic [31:0] cb(input int c);
		return 32'hA0000008 + 32'h14 * 32'(c);
	endfunction

	task automatic chk(input string w, input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", w, e, g);
		end
	endtask

	task automatic test_done();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One Avalon access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		@(posedge clk);
		a_addr <= a;
		a_rd <= !w;
		a_wr <= w;
		a_wd <= d;
		do @(posedge clk); while (waitr !== 1'b0);
		q = rdata;
		a_rd <= 1'b0;
		a_wr <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [31:0] a, e);
		logic [31:0] q;
		exp_q.push_back({32'hFFFFFFFF, e});
		bus(1'b0, a, 32'h0, q);
	endtask

	// Polls the status word until the given flag bit is set.
	task automatic wait_flag(input int b);
		logic [31:0] d;
		d = 32'h0;
		while (d[b] !== 1'b1) begin
			exp_q.push_back(64'h0);
			bus(1'b0, FLAGS_A, 32'h0, d);
		end
	endtask

	// Programs count, addresses, then the configuration word last.
	task automatic prog(input int c, input logic [31:0] n, pa, ma, cfg);
		wr(cb(c) + 32'h4, n);
		wr(cb(c) + 32'h8, pa);
		wr(cb(c) + 32'hC, ma);
		wr(cb(c), cfg);
	endtask

	// Compares each completed register read with the oldest note.
	always @(posedge clk) begin
		logic [63:0] x;
		if (a_rd && waitr === 1'b0) begin
			x = exp_q.pop_front();
			chk("readdata", rdata & x[63:32], x[31:0]);
		end
	end

	// Notes the element width of each accepted master write.
	always @(posedge clk) begin
		if (m_wr && s_wait === 1'b0) begin
			wsz <= m_size;
		end
	end

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		test_done();
	end

	// Main sequence.
	initial begin
		logic [31:0] v;
		int n;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 4; r++) begin
				rd(cb(c) + 32'(4 * r), 32'h0);
			end
		end
		rd(32'hA00000A8, 32'h0);
		v = rnd();
		wr(32'hA0000094, v & 32'hFFFFFFFE);
		rd(cb(7), v & 32'h00007FFE);
		rd(32'hA0000030 + 32'h64, v & 32'h00007FFE);
		rd(cb(6), 32'h0);
		wr(cb(7) + 32'h4, v);
		rd(cb(7) + 32'h4, v & 32'h0000FFFF);
		for (int k = 0; k < 4; k++) begin
			v = 32'(k) * 32'h1540;
			wr(cb(7), v);
			rd(cb(7), v);
		end
		wr(cb(7), 32'h0);
		wr(cb(7) + 32'h4, 32'h0);
		v = 32'h1000 | (rnd() & 32'h3);
		prog(2, 32'h4, v, 32'h2001, 32'h687);
		preq[2] <= 1'b1;
		wait_flag(9);
		preq[2] <= 1'b0;
		rd(cb(2) + 32'h4, 32'h0);
		rd(FLAGS_A, 32'h700);
		chk("irq2", {31'h0, irq[2]}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			chk("mem", p.mem[32'h2000 + 32'(2 * i)], 32'h1000 ^ PT);
		end
		chk("reads", 32'(p.rd_log.size()), 32'h4);
		chk("src", p.rd_log[3], 32'h1000);
		chk("wsize", {30'h0, wsz}, 32'h1);
		wr(cb(2) + 32'h4, 32'h5);
		rd(cb(2) + 32'h4, 32'h0);
		preq[2] <= 1'b1;
		repeat (20) @(posedge clk);
		chk("idle", 32'(p.rd_log.size()), 32'h4);
		preq[2] <= 1'b0;
		wr(CL, 32'h100);
		rd(FLAGS_A, 32'h0);
		chk("irq2", {31'h0, irq[2]}, 32'h0);
		wr(cb(2), 32'h0);
		fault <= 32'h4000;
		prog(5, 32'h3, 32'h4000, 32'h3000, 32'hA19);
		preq[5] <= 1'b1;
		wait_flag(23);
		preq[5] <= 1'b0;
		chk("src", p.rd_log[$], 32'h3000);
		rd(cb(5), 32'hA18);
		rd(cb(5) + 32'h4, 32'h3);
		rd(FLAGS_A, 32'h00900000);
		chk("irq5", {31'h0, irq[5]}, 32'h1);
		wr(CL, 32'h00100000);
		rd(FLAGS_A, 32'h0);
		prog(3, 32'h2, 32'h5000, 32'h6000, 32'h40E1);
		wait_flag(13);
		repeat (30) @(posedge clk);
		chk("irq3", {31'h0, irq[3]}, 32'h0);
		wr(cb(3), 32'h0);
		repeat (5) @(posedge clk);
		n = p.n_wr;
		repeat (20) @(posedge clk);
		chk("stop", 32'(p.n_wr), 32'(n));
		chk("auto_reload_mode", 32'(n > 6), 32'h1);
		chk("wsize", {30'h0, wsz}, 32'h0);
		chk("wrap", 32'(p.mem.exists(32'h6002)), 32'h0);
		chk("copy", p.mem[32'h6001], 32'h5001 ^ PT);
		wr(CL, 32'h1000);
		prog(6, 32'h1, 32'h7000, 32'h8000, 32'h1);
		prog(7, 32'h1, 32'h7100, 32'h8100, 32'h3001);
		p.rd_log.delete();
		preq <= 8'hC0;
		while (p.rd_log.size() < 2) @(posedge clk);
		preq <= 8'h0;
		chk("grant", p.rd_log[0], 32'h7100);
		repeat (10) @(posedge clk);
		test_done();
	end
endmodule
`default_nettype wire

// ---- sim/dmacc_slave.sv ----
// Behavioural memory and peripheral slave on the engine's master bus.
`timescale 1ns/1ps
`default_nettype none
module dmacc_slave (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [31:0] i_addr,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_wdata,
	input wire logic [31:0] i_fault,
	output logic [31:0] o_rdata,
	output logic o_wait,
	output logic o_err
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] rd_log [$];
	int n_wr = 0;
	int stall = 0;
	int cnt = 0;
	// Answers after 0 to 2 stall cycles; released read data toggles.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_wait <= 1'b1;
			o_err <= 1'b0;
			o_rdata <= 32'h0;
			cnt = 0;
		end else if ((i_read || i_write) && o_wait) begin
			if (cnt == 0) begin
				o_wait <= 1'b0;
				o_err <= (i_addr == i_fault);
				stall = stall + 1;
				if (i_read) begin
					rd_log.push_back(i_addr);
					o_rdata <= mem.exists(i_addr) ? mem[i_addr] :
						i_addr ^ 32'h5A5A0000;
				end else if (i_addr != i_fault) begin
					mem[i_addr] = i_wdata;
					n_wr = n_wr + 1;
				end
			end else begin
				cnt = cnt - 1;
			end
		end else begin
			o_wait <= 1'b1;
			o_err <= 1'b0;
			o_rdata <= ~o_rdata;
			cnt = stall % 3;
		end
	end
endmodule
`default_nettype wire
